//--- pkg/tplrs_pkg.sv
// types shared by the lane route select block
package tplrs_pkg;

    // ************************************************************
    // lane output drive state
    // ************************************************************
    typedef enum logic [1:0] {
        TPLRS_OUT_OFF,
        TPLRS_OUT_SQUELCH,
        TPLRS_OUT_DATA
    } tplrs_drive_t;

    // ************************************************************
    // source of a lane output
    // ************************************************************
    typedef enum logic [1:0] {
        TPLRS_SRC_LINE,
        TPLRS_SRC_FAB_A,
        TPLRS_SRC_FAB_B,
        TPLRS_SRC_NONE
    } tplrs_src_t;

    // routing settings for all lanes
    typedef struct packed {
        logic       loop_line;
        logic       loop_fab_a;
        logic       loop_fab_b;
        logic       diag;
        logic       sq_line;
        logic       sq_fab_a;
        logic       sq_fab_b;
        logic       power_down;
        logic [3:0] sel;
        logic [3:0] lane_enable;
    } tplrs_cfg_t;

    // one lane's per-port data
    typedef struct packed {
        logic line;
        logic fab_a;
        logic fab_b;
    } tplrs_lane_t;

endpackage

//--- pkg/tplrs_regs.svh
// register offsets, field positions, reset values and timing counts for the lane route select block
`ifndef TPLRS_REGS_SVH
`define TPLRS_REGS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define TPLRS_CTRL_OFS      12'h000
`define TPLRS_LANE_OFS      12'h004
`define TPLRS_STAT_OFS      12'h008

// ************************************************************
// control register fields
// ************************************************************
`define TPLRS_CTRL_LOOP_L   0
`define TPLRS_CTRL_LOOP_A   1
`define TPLRS_CTRL_LOOP_B   2
`define TPLRS_CTRL_DIAG     3
`define TPLRS_CTRL_SQL      4
`define TPLRS_CTRL_SQA      5
`define TPLRS_CTRL_SQB      6
`define TPLRS_CTRL_PDN      7
`define TPLRS_CTRL_SEL_LO   8
`define TPLRS_CTRL_SEL_HI   11
`define TPLRS_CTRL_RST      32'h0000_0070

// ************************************************************
// lane register fields
// ************************************************************
`define TPLRS_LANE_EN_HI    3
`define TPLRS_LANE_RST      4'hf

// ************************************************************
// switch settle times
// ************************************************************
`define TPLRS_CLK_MHZ       50
`define TPLRS_T_SQ_NS       100
`define TPLRS_T_OFF_US      10
`define TPLRS_SQ_CYC        ((`TPLRS_T_SQ_NS * `TPLRS_CLK_MHZ) / 1000)
`define TPLRS_OFF_CYC       (`TPLRS_T_OFF_US * `TPLRS_CLK_MHZ)
`define TPLRS_CNT_W         10

`endif

//--- rtl/tplrs_lane_map.sv
// combinational source decode for one lane
`timescale 1ns/1ps

module tplrs_lane_map
    import tplrs_pkg::*;
(
    input  wire logic       loop_line,
    input  wire logic       loop_fab_a,
    input  wire logic       loop_fab_b,
    input  wire logic       diag,
    input  wire logic       sel,
    output tplrs_src_t      src_line,
    output tplrs_src_t      src_fab_a,
    output tplrs_src_t      src_fab_b
);

    // line output: own input in loopback, else the selected fabric port
    // line loopback wins
    always_comb begin
        if (loop_line) begin
            src_line = TPLRS_SRC_LINE;
        end else if (sel) begin
            src_line = TPLRS_SRC_FAB_B;
        end else begin
            src_line = TPLRS_SRC_FAB_A;
        end
    end

    // fabric a: loopback, else line when selected or broadcasting
    // diag broadcast
    always_comb begin
        if (loop_fab_a) begin
            src_fab_a = TPLRS_SRC_FAB_A;
        end else if (diag || !sel) begin
            src_fab_a = TPLRS_SRC_LINE;
        end else begin
            src_fab_a = TPLRS_SRC_NONE;
        end
    end

    // fabric b: loopback, else line when selected or broadcasting
    // diag broadcast
    always_comb begin
        if (loop_fab_b) begin
            src_fab_b = TPLRS_SRC_FAB_B;
        end else if (diag || sel) begin
            src_fab_b = TPLRS_SRC_LINE;
        end else begin
            src_fab_b = TPLRS_SRC_NONE;
        end
    end

endmodule

//--- rtl/tplrs_route.sv
// three port, four lane route select with apb control
`timescale 1ns/1ps
`include "tplrs_regs.svh"

// Overview of operation
// - select zero pairs line with fabric a
// - select one pairs line with fabric b
// - diagnostic zero broadcasts line, returns fabric a
// - diagnostic one broadcasts line, returns fabric b
// - line loopback returns line input
// - fabric b loopback returns its own input
// - fabric a loopback returns its own input
// - loopbacks combine freely and independently
// - four select bits, one per lane
// - squelched idle outputs settle in 100 ns
// - disabled idle outputs settle in 10 us
// - per-port setting squelches or disables idle outputs
// - per-lane enable covers all ports
// - power-down disables everything, resets configuration
module tplrs_route
    import tplrs_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [3:0]   in_line,
    input  wire logic [3:0]   in_fab_a,
    input  wire logic [3:0]   in_fab_b,
    output logic      [3:0]   out_line,
    output logic      [3:0]   out_fab_a,
    output logic      [3:0]   out_fab_b,
    output tplrs_drive_t [3:0] drv_line,
    output tplrs_drive_t [3:0] drv_fab_a,
    output tplrs_drive_t [3:0] drv_fab_b,
    output logic      [3:0]   valid_line,
    output logic      [3:0]   valid_fab_a,
    output logic      [3:0]   valid_fab_b
);

    import tplrs_pkg::*;

    // ************************************************************
    // registers and wires
    // ************************************************************
    tplrs_cfg_t    cfg_reg;
    tplrs_cfg_t    cfg_next;
    tplrs_lane_t   din_s1_reg [3:0];
    tplrs_lane_t   din_s2_reg [3:0];
    tplrs_src_t    src_l [3:0];
    tplrs_src_t    src_a [3:0];
    tplrs_src_t    src_b [3:0];
    tplrs_src_t    prev_l_reg [3:0];
    tplrs_src_t    prev_a_reg [3:0];
    tplrs_src_t    prev_b_reg [3:0];
    logic [3:0]    vl;
    logic [3:0]    va;
    logic [3:0]    vb;
    logic          wr_acc;
    logic          rd_acc;
    logic          addr_ok;
    logic [31:0]   rd_data;

    // reset image of the configuration, built field by field from the register layout
    localparam logic [31:0] ctrl_rst_word = `TPLRS_CTRL_RST;
    localparam tplrs_cfg_t  cfg_rst       = '{
        loop_line:   ctrl_rst_word[`TPLRS_CTRL_LOOP_L],
        loop_fab_a:  ctrl_rst_word[`TPLRS_CTRL_LOOP_A],
        loop_fab_b:  ctrl_rst_word[`TPLRS_CTRL_LOOP_B],
        diag:        ctrl_rst_word[`TPLRS_CTRL_DIAG],
        sq_line:     ctrl_rst_word[`TPLRS_CTRL_SQL],
        sq_fab_a:    ctrl_rst_word[`TPLRS_CTRL_SQA],
        sq_fab_b:    ctrl_rst_word[`TPLRS_CTRL_SQB],
        power_down:  ctrl_rst_word[`TPLRS_CTRL_PDN],
        sel:         ctrl_rst_word[`TPLRS_CTRL_SEL_HI:`TPLRS_CTRL_SEL_LO],
        lane_enable: `TPLRS_LANE_RST
    };

    // ************************************************************
    // apb slave
    // ************************************************************
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && !penable && !pwrite;
    assign addr_ok = (paddr == `TPLRS_CTRL_OFS) || (paddr == `TPLRS_LANE_OFS) || (paddr == `TPLRS_STAT_OFS);

    // ready on every access phase, error on unmapped address
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (paddr)
            `TPLRS_CTRL_OFS: rd_data = {20'h00000, cfg_reg.sel, cfg_reg.power_down, cfg_reg.sq_fab_b,
                                        cfg_reg.sq_fab_a, cfg_reg.sq_line, cfg_reg.diag,
                                        cfg_reg.loop_fab_b, cfg_reg.loop_fab_a, cfg_reg.loop_line};
            `TPLRS_LANE_OFS: rd_data = {28'h0000000, cfg_reg.lane_enable};
            `TPLRS_STAT_OFS: rd_data = {20'h00000, valid_fab_b, valid_fab_a, valid_line};
            default:         rd_data = 32'h0000_0000;
        endcase
    end

    // read data captured in setup, held through access
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            prdata <= rd_data;
        end
    end

    // ************************************************************
    // configuration
    // ************************************************************
    // write decode; power-down returns everything else to its reset value
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_acc && paddr == `TPLRS_CTRL_OFS) begin
            cfg_next.loop_line  = pwdata[`TPLRS_CTRL_LOOP_L];
            cfg_next.loop_fab_a = pwdata[`TPLRS_CTRL_LOOP_A];
            cfg_next.loop_fab_b = pwdata[`TPLRS_CTRL_LOOP_B];
            cfg_next.diag       = pwdata[`TPLRS_CTRL_DIAG];
            cfg_next.sq_line    = pwdata[`TPLRS_CTRL_SQL];
            cfg_next.sq_fab_a   = pwdata[`TPLRS_CTRL_SQA];
            cfg_next.sq_fab_b   = pwdata[`TPLRS_CTRL_SQB];
            cfg_next.power_down = pwdata[`TPLRS_CTRL_PDN];
            cfg_next.sel        = pwdata[`TPLRS_CTRL_SEL_HI:`TPLRS_CTRL_SEL_LO];
        end
        if (wr_acc && paddr == `TPLRS_LANE_OFS) begin
            cfg_next.lane_enable = pwdata[`TPLRS_LANE_EN_HI:0];
        end
        if (cfg_next.power_down) begin
            cfg_next            = cfg_rst;
            cfg_next.power_down = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= cfg_rst;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ************************************************************
    // per-lane routing
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            tplrs_lane_map u_map (
                .loop_line  (cfg_reg.loop_line),
                .loop_fab_a (cfg_reg.loop_fab_a),
                .loop_fab_b (cfg_reg.loop_fab_b),
                .diag       (cfg_reg.diag),
                .sel        (cfg_reg.sel[g]),
                .src_line   (src_l[g]),
                .src_fab_a  (src_a[g]),
                .src_fab_b  (src_b[g])
            );

            tplrs_settle u_sl (
                .core_clk (core_clk),
                .reset    (reset),
                .change   (src_l[g] != prev_l_reg[g]),
                .squelch  (cfg_reg.sq_line),
                .valid    (vl[g])
            );
            tplrs_settle u_sa (
                .core_clk (core_clk),
                .reset    (reset),
                .change   (src_a[g] != prev_a_reg[g]),
                .squelch  (cfg_reg.sq_fab_a),
                .valid    (va[g])
            );
            tplrs_settle u_sb (
                .core_clk (core_clk),
                .reset    (reset),
                .change   (src_b[g] != prev_b_reg[g]),
                .squelch  (cfg_reg.sq_fab_b),
                .valid    (vb[g])
            );

            // two-stage synchroniser for lane inputs
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    din_s1_reg[g] <= '0;
                    din_s2_reg[g] <= '0;
                end else begin
                    din_s1_reg[g] <= '{line: in_line[g], fab_a: in_fab_a[g], fab_b: in_fab_b[g]};
                    din_s2_reg[g] <= din_s1_reg[g];
                end
            end

            // previous sources for change detect
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    prev_l_reg[g] <= TPLRS_SRC_FAB_A;
                    prev_a_reg[g] <= TPLRS_SRC_LINE;
                    prev_b_reg[g] <= TPLRS_SRC_NONE;
                end else begin
                    prev_l_reg[g] <= src_l[g];
                    prev_a_reg[g] <= src_a[g];
                    prev_b_reg[g] <= src_b[g];
                end
            end

            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    out_line[g]  <= 1'b0;
                    out_fab_a[g] <= 1'b0;
                    out_fab_b[g] <= 1'b0;
                end else begin
                    out_line[g]  <= pick(src_l[g], din_s2_reg[g]) && lane_on(g);
                    out_fab_a[g] <= pick(src_a[g], din_s2_reg[g]) && lane_on(g);
                    out_fab_b[g] <= pick(src_b[g], din_s2_reg[g]) && lane_on(g);
                end
            end

            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    drv_line[g]    <= TPLRS_OUT_OFF;
                    drv_fab_a[g]   <= TPLRS_OUT_OFF;
                    drv_fab_b[g]   <= TPLRS_OUT_OFF;
                    valid_line[g]  <= 1'b0;
                    valid_fab_a[g] <= 1'b0;
                    valid_fab_b[g] <= 1'b0;
                end else begin
                    drv_line[g]    <= drive(src_l[g], cfg_reg.sq_line, lane_on(g));
                    drv_fab_a[g]   <= drive(src_a[g], cfg_reg.sq_fab_a, lane_on(g));
                    drv_fab_b[g]   <= drive(src_b[g], cfg_reg.sq_fab_b, lane_on(g));
                    valid_line[g]  <= vl[g] && lane_on(g) && src_l[g] != TPLRS_SRC_NONE;
                    valid_fab_a[g] <= va[g] && lane_on(g) && src_a[g] != TPLRS_SRC_NONE;
                    valid_fab_b[g] <= vb[g] && lane_on(g) && src_b[g] != TPLRS_SRC_NONE;
                end
            end
        end
    endgenerate

    // ************************************************************
    // helpers
    // ************************************************************
    // lane is live when enabled and not powered down
    function automatic logic lane_on(input int idx);
        return cfg_reg.lane_enable[idx] && !cfg_reg.power_down;
    endfunction

    // data bit of the chosen source
    function automatic logic pick(input tplrs_src_t s, input tplrs_lane_t d);
        logic r;
        r = 1'b0;
        unique case (s)
            TPLRS_SRC_LINE:  r = d.line;
            TPLRS_SRC_FAB_A: r = d.fab_a;
            TPLRS_SRC_FAB_B: r = d.fab_b;
            TPLRS_SRC_NONE:  r = 1'b0;
        endcase
        return r;
    endfunction

    // idle outputs squelched or off per port setting
    function automatic tplrs_drive_t drive(input tplrs_src_t s, input logic sq, input logic on);
        tplrs_drive_t r;
        r = TPLRS_OUT_OFF;
        if (on && s != TPLRS_SRC_NONE) begin
            r = TPLRS_OUT_DATA;
        end else if (on && sq) begin
            r = TPLRS_OUT_SQUELCH;
        end
        return r;
    endfunction

    // ************************************************************
    // assertions
    // ************************************************************
    property p_norm_sel0;
        @(posedge core_clk) disable iff (reset)
        (!cfg_reg.loop_fab_b && !cfg_reg.diag && !cfg_reg.sel[0] && lane_on(0))
            |=> drv_fab_b[0] != TPLRS_OUT_DATA;
    endproperty
    a_norm_sel0: assert property (p_norm_sel0) else $error("fabric b driven while idle");

    property p_norm_sel1;
        @(posedge core_clk) disable iff (reset)
        (!cfg_reg.loop_fab_a && !cfg_reg.diag && cfg_reg.sel[0] && lane_on(0))
            |=> drv_fab_a[0] != TPLRS_OUT_DATA;
    endproperty
    a_norm_sel1: assert property (p_norm_sel1) else $error("fabric a driven while idle");

    property p_diag_bcast;
        @(posedge core_clk) disable iff (reset)
        (cfg_reg.diag && !cfg_reg.loop_fab_a && !cfg_reg.loop_fab_b && lane_on(1))
            |=> drv_fab_a[1] == TPLRS_OUT_DATA && drv_fab_b[1] == TPLRS_OUT_DATA;
    endproperty
    a_diag_bcast: assert property (p_diag_bcast) else $error("diagnostic broadcast missing");

    property p_line_loop;
        @(posedge core_clk) disable iff (reset)
        (cfg_reg.loop_line && lane_on(2)) |=> out_line[2] == $past(din_s2_reg[2].line);
    endproperty
    a_line_loop: assert property (p_line_loop) else $error("line loopback data wrong");

    property p_fb_loop;
        @(posedge core_clk) disable iff (reset)
        (cfg_reg.loop_fab_b && lane_on(3)) |=> out_fab_b[3] == $past(din_s2_reg[3].fab_b);
    endproperty
    a_fb_loop: assert property (p_fb_loop) else $error("fabric b loopback data wrong");

    property p_fa_loop;
        @(posedge core_clk) disable iff (reset)
        (cfg_reg.loop_fab_a && lane_on(0)) |=> out_fab_a[0] == $past(din_s2_reg[0].fab_a);
    endproperty
    a_fa_loop: assert property (p_fa_loop) else $error("fabric a loopback data wrong");

    property p_lane_off;
        @(posedge core_clk) disable iff (reset)
        !lane_on(1) |=> drv_line[1] == TPLRS_OUT_OFF && !valid_line[1];
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("disabled lane still driven");

    sequence s_sq_change;
        src_l[0] != prev_l_reg[0] && cfg_reg.sq_line && lane_on(0);
    endsequence
    property p_sq_settle;
        @(posedge core_clk) disable iff (reset)
        s_sq_change ##1 (src_l[0] == prev_l_reg[0] && cfg_reg.sq_line && lane_on(0))[*6]
            |=> valid_line[0];
    endproperty
    a_sq_settle: assert property (p_sq_settle) else $error("squelched switch too slow");

endmodule

//--- rtl/tplrs_settle.sv
// per-output settle timer after a source change
`timescale 1ns/1ps
`include "tplrs_regs.svh"

module tplrs_settle
    import tplrs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       change,
    input  wire logic       squelch,
    output logic            valid
);

    logic [`TPLRS_CNT_W-1:0] cnt_reg;

    // reload on a change, count down to zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
        end else if (change) begin
            cnt_reg <= squelch ? `TPLRS_CNT_W'(`TPLRS_SQ_CYC) : `TPLRS_CNT_W'(`TPLRS_OFF_CYC);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - `TPLRS_CNT_W'(1);
        end
    end

    assign valid = (cnt_reg == '0) && !change;

endmodule

//--- testbench/three_port_lane_route_select_bench.sv
// self-checking bench for the lane route select block
`timescale 1ns/1ps
`include "tplrs_regs.svh"

module three_port_lane_route_select_bench;
    import tplrs_pkg::*;
    logic               core_clk = 1'b0;
    logic               reset, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [1:0]         hot;
    logic [3:0]         in_line, in_fab_a, in_fab_b, out_line, out_fab_a, out_fab_b;
    logic [3:0]         valid_line, valid_fab_a, valid_fab_b;
    tplrs_drive_t [3:0] drv_line, drv_fab_a, drv_fab_b;
    int                 error_cnt = 0;
    int                 checks_done = 0;
    int                 n;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    tplrs_route u_tplrs_route (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_line(in_line), .in_fab_a(in_fab_a), .in_fab_b(in_fab_b), .out_line(out_line),
        .out_fab_a(out_fab_a), .out_fab_b(out_fab_b), .drv_line(drv_line), .drv_fab_a(drv_fab_a),
        .drv_fab_b(drv_fab_b), .valid_line(valid_line), .valid_fab_a(valid_fab_a), .valid_fab_b(valid_fab_b));

    tplrs_xcvr_model u_tplrs_xcvr_model (.hot(hot), .in_line(in_line), .in_fab_a(in_fab_a), .in_fab_b(in_fab_b));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // apb transfer, held until pready is sampled high, then one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // source per port: 0 line, 1 fabric a, 2 fabric b, 3 idle
    function automatic logic [1:0] src_of(input int p, input logic [3:0] c, input logic s);
        case (p)
            0: return c[0] ? 2'd0 : (s ? 2'd2 : 2'd1);
            1: return c[1] ? 2'd1 : ((c[3] || !s) ? 2'd0 : 2'd3);
            default: return c[2] ? 2'd2 : ((c[3] || s) ? 2'd0 : 2'd3);
        endcase
    endfunction

    // drive each port hot in turn and compare data and drive state
    task automatic vfy(input logic [31:0] c, input logic [3:0] en);
        tplrs_drive_t [3:0] ed;
        logic [3:0]         eo;
        logic [1:0]         s;
        for (int h = 0; h < 3; h++) begin
            hot <= h[1:0];
            repeat (6) @(posedge core_clk);
            for (int p = 0; p < 3; p++) begin
                for (int l = 0; l < 4; l++) begin
                    s = src_of(p, c[3:0], c[8+l]);
                    eo[l] = en[l] && (s == h[1:0]);
                    ed[l] = !en[l] ? TPLRS_OUT_OFF : (s != 2'd3) ? TPLRS_OUT_DATA :
                            (c[4+p] ? TPLRS_OUT_SQUELCH : TPLRS_OUT_OFF);
                end
                chk({28'h0, p == 0 ? out_line : p == 1 ? out_fab_a : out_fab_b}, {28'h0, eo}, "out");
                chk({24'h0, p == 0 ? drv_line : p == 1 ? drv_fab_a : drv_fab_b}, {24'h0, ed}, "drv");
            end
        end
    endtask

    // cycles until fabric b lane 0 shows valid data, sampled on the falling edge
    task automatic settle();
        n = 0;
        while (valid_fab_b[0] !== 1'b1 && n < 700) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hot = 2'd0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, `TPLRS_CTRL_OFS, 32'h0);
        chk(rd, `TPLRS_CTRL_RST, "ctrl reset");
        apb(1'b0, `TPLRS_LANE_OFS, 32'h0);
        chk(rd, {28'h0, `TPLRS_LANE_RST}, "lane reset");
        chk({31'h0, er}, 32'h0, "mapped err");
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped read err");
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        chk({31'h0, er}, 32'h1, "unmapped err");
        $display("test registers done");
        // every loopback and diagnostic mix, lanes split by select
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, `TPLRS_CTRL_OFS, 32'h570 | c);
            vfy(32'h570 | c, 4'hf);
        end
        $display("test routing done");
        // lane enable and disabled idle outputs
        apb(1'b1, `TPLRS_LANE_OFS, 32'h5);
        apb(1'b1, `TPLRS_CTRL_OFS, 32'h330);
        vfy(32'h330, 4'h5);
        apb(1'b1, `TPLRS_LANE_OFS, 32'hf);
        $display("test lane enable done");
        // power down resets config to reset values and turns all off
        apb(1'b1, `TPLRS_CTRL_OFS, 32'h80);
        apb(1'b0, `TPLRS_CTRL_OFS, 32'h0);
        chk(rd, 32'hf0, "ctrl in power down");
        vfy(32'hf0, 4'h0);
        apb(1'b1, `TPLRS_CTRL_OFS, 32'h070);
        $display("test power down done");
        // switch time, squelched then disabled idle outputs
        repeat (20) @(posedge core_clk);
        apb(1'b1, `TPLRS_CTRL_OFS, 32'h170);
        settle();
        chk({31'h0, n >= 5 && n <= 9}, 32'h1, "fast settle");
        apb(1'b0, `TPLRS_STAT_OFS, 32'h0);
        chk(rd, 32'h0000_01ef, "stat valid");
        apb(1'b1, `TPLRS_CTRL_OFS, 32'h070);
        repeat (10) @(posedge core_clk);
        apb(1'b1, `TPLRS_CTRL_OFS, 32'h100);
        settle();
        chk({31'h0, n >= 500 && n <= 506}, 32'h1, "slow settle");
        $display("test switch time done");
        close_out();
    end
endmodule

//--- testbench/tplrs_xcvr_model.sv
// serial transceiver stand-in driving the three port inputs
`timescale 1ns/1ps

module tplrs_xcvr_model (
    input  wire logic [1:0] hot,
    output logic      [3:0] in_line,
    output logic      [3:0] in_fab_a,
    output logic      [3:0] in_fab_b
);
    // ************************************************************
    // lane data
    // ************************************************************
    // hot port sends ones on every lane, the others send zeros
    assign in_line  = {4{hot == 2'd0}};
    assign in_fab_a = {4{hot == 2'd1}};
    assign in_fab_b = {4{hot == 2'd2}};
endmodule
